// ===== verilog/usm_top.sv
// infrared, LIN break and smart-card extensions of a serial transceiver
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module usm_top
  import usm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ovs_tick,
  input wire logic lp_tick,
  input wire logic core_tx,
  input wire logic core_tx_busy,
  input wire logic core_rx_busy,
  input wire logic core_frame_end,
  input wire logic core_parity_err,
  input wire logic core_rx_stop_end,
  input wire logic core_rx_zero_fe,
  output logic core_rx,
  output logic core_break_rx,
  output logic ir_tx,
  input wire logic ir_rx_pin,
  input wire logic data_in_pin,
  output logic data_out,
  output logic data_oe_b,
  output logic card_clk,
  output logic break_irq
);
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] psc_q, psc_d;
  logic [7:0] gt_q, gt_d;
  logic [3:0] sts_q, sts_d;
  logic [31:0] rdata_d;
  logic brk_found;

  logic ir_s1_q, ir_s2_q, dat_s1_q, dat_s2_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ir_s1_q <= 1'b1;
      ir_s2_q <= 1'b1;
      dat_s1_q <= 1'b1;
      dat_s2_q <= 1'b1;
    end else begin
      ir_s1_q <= ir_rx_pin;
      ir_s2_q <= ir_s1_q;
      dat_s1_q <= data_in_pin;
      dat_s2_q <= dat_s1_q;
    end
  end

  // prescaler clock: also the card clock source and the normal-mode filter clock
  logic [7:0] pcnt_q, pcnt_d;
  logic ptick;
  logic cclk_q, cclk_d;
  assign ptick = (pcnt_q == 8'h00);
  always_comb begin
    pcnt_d = ptick ? (psc_q == 8'h00 ? 8'h00 : psc_q - 8'h01) : pcnt_q - 8'h01;
    cclk_d = cclk_q;
    if (!ctrl_q[CTRL_SC_EN]) begin
      cclk_d = 1'b0;
    end else if (ptick) begin
      cclk_d = ~cclk_q;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pcnt_q <= 8'h00;
      cclk_q <= 1'b0;
    end else begin
      pcnt_q <= pcnt_d;
      cclk_q <= cclk_d;
    end
  end

  // infrared encoder: one-shot on each falling edge of the bit stream, none while core_rx_busy is high
  logic tx_prev_q, tx_prev_d;
  logic [3:0] irc_q, irc_d;
  logic irp_q, irp_d;
  logic ir_active;
  assign ir_active = ctrl_q[CTRL_IR_EN];
  always_comb begin
    tx_prev_d = core_tx;
    irc_d = irc_q;
    irp_d = irp_q;
    if (!ir_active || core_rx_busy) begin
      irp_d = 1'b0;
    end else if (tx_prev_q && !core_tx) begin
      irp_d = 1'b1;
      irc_d = 4'h0;
    end else if (irp_q) begin
      if (ctrl_q[CTRL_IR_LP]) begin
        if (lp_tick) begin
          irc_d = irc_q + 4'h1;
          if (irc_q + 4'h1 == {2'b00, IR_LP_PULSE_CYC}) irp_d = 1'b0;
        end
      end else if (ovs_tick) begin
        irc_d = irc_q + 4'h1;
        if (irc_q + 4'h1 == IR_PULSE_SIXTEENTHS) irp_d = 1'b0;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_prev_q <= 1'b1;
      irc_q <= 4'h0;
      irp_q <= 1'b0;
    end else begin
      tx_prev_q <= tx_prev_d;
      irc_q <= irc_d;
      irp_q <= irp_d;
    end
  end

  // infrared decoder: low input held long enough stretches to a zero bit
  logic [1:0] flt_q, flt_d;
  logic [3:0] hold_q, hold_d;
  logic dec_q, dec_d;
  logic ftick;
  assign ftick = ctrl_q[CTRL_IR_LP] ? lp_tick : ptick;
  always_comb begin
    flt_d = flt_q;
    hold_d = hold_q;
    dec_d = dec_q;
    if (!ir_active || core_tx_busy || ir_s2_q) begin
      flt_d = 2'h0;
    end else if (ftick && flt_q != IR_FILT_CYC) begin
      flt_d = flt_q + 2'h1;
    end
    if (flt_q == IR_FILT_CYC && !ir_s2_q && !core_tx_busy) begin
      dec_d = 1'b0;
      hold_d = 4'h0;
    end else if (!dec_q && ovs_tick) begin
      hold_d = hold_q + 4'h1;
      if (hold_q == OVS_LAST) dec_d = 1'b1;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flt_q <= 2'h0;
      hold_q <= 4'h0;
      dec_q <= 1'b1;
    end else begin
      flt_q <= flt_d;
      hold_q <= hold_d;
      dec_q <= dec_d;
    end
  end

  // LIN break sender and smart-card NACK/guard timing, counted in bit periods
  logic [3:0] bph_q, bph_d;
  logic bit_tick;
  logic [3:0] brk_bits_q, brk_bits_d;
  logic nack_q, nack_d;
  logic [1:0] nseen_q, nseen_d;
  logic [7:0] gcnt_q, gcnt_d;
  logic grun_q, grun_d;
  logic txc_set, fe_set;
  assign bit_tick = ovs_tick && bph_q == OVS_LAST;
  always_comb begin
    bph_d = ovs_tick ? bph_q + 4'h1 : bph_q;
    brk_bits_d = brk_bits_q;
    nack_d = nack_q;
    nseen_d = nseen_q;
    gcnt_d = gcnt_q;
    grun_d = grun_q;
    txc_set = 1'b0;
    fe_set = 1'b0;
    if (ctrl_q[CTRL_SEND_BRK] && brk_bits_q == 4'h0 && ctrl_q[CTRL_LIN_EN]) begin
      brk_bits_d = BRK_SEND_BITS;
      bph_d = 4'h0;
    end else if (bit_tick && brk_bits_q != 4'h0) begin
      brk_bits_d = brk_bits_q - 4'h1;
    end
    if (ctrl_q[CTRL_SC_EN] && ctrl_q[CTRL_SC_NACK] && core_parity_err && core_rx_stop_end) begin
      nack_d = 1'b1;
      bph_d = 4'h0;
    end else if (bit_tick) begin
      nack_d = 1'b0;
    end
    // transmitter side: a low during the stop bits is a NACK, not a start
    if (ctrl_q[CTRL_SC_EN] && core_tx_busy && core_tx && !dat_s2_q) begin
      if (bit_tick && nseen_q != NACK_MAX_BITS) nseen_d = nseen_q + 2'h1;
    end else if (!core_tx_busy) begin
      nseen_d = 2'h0;
    end
    if (ctrl_q[CTRL_SC_EN] && core_tx_busy && core_tx && !dat_s2_q && nseen_q == 2'h0 && bit_tick) begin
      fe_set = 1'b1;
    end
    if (core_frame_end && ctrl_q[CTRL_SC_EN]) begin
      grun_d = 1'b1;
      gcnt_d = 8'h00;
    end else if (grun_q && bit_tick) begin
      gcnt_d = gcnt_q + 8'h01;
      if (gcnt_q + 8'h01 >= gt_q) begin
        grun_d = 1'b0;
        txc_set = 1'b1;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bph_q <= 4'h0;
      brk_bits_q <= 4'h0;
      nack_q <= 1'b0;
      nseen_q <= 2'h0;
      gcnt_q <= 8'h00;
      grun_q <= 1'b0;
    end else begin
      bph_q <= bph_d;
      brk_bits_q <= brk_bits_d;
      nack_q <= nack_d;
      nseen_q <= nseen_d;
      gcnt_q <= gcnt_d;
      grun_q <= grun_d;
    end
  end

  usm_break_det u_brk (
    .clock(clock),
    .rst_b(rst_b),
    .enable(ctrl_q[CTRL_LIN_EN]),
    .ovs_tick(ovs_tick),
    .rx(dat_s2_q),
    .long_sel(ctrl_q[CTRL_BRK_LEN]),
    .found(brk_found)
  );

  // register port; hardware set wins over software clear
  always_comb begin
    ctrl_d = ctrl_q;
    psc_d = psc_q;
    gt_d = gt_q;
    sts_d = sts_q;
    rdata_d = 32'h0000_0000;
    if (brk_bits_q == 4'h1 && bit_tick) ctrl_d[CTRL_SEND_BRK] = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: ctrl_d = reg_wdata[7:0];
        REG_GTP: begin
          psc_d = reg_wdata[7:0];
          gt_d = reg_wdata[15:8];
        end
        REG_STS: sts_d = sts_q & reg_wdata[3:0];
        default: ;
      endcase
    end
    if (brk_found) sts_d[STS_BRK] = 1'b1;
    if (txc_set) sts_d[STS_TXC] = 1'b1;
    if (fe_set) sts_d[STS_FE] = 1'b1;
    sts_d[STS_TXE] = ~core_tx_busy;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: rdata_d = {24'h00_0000, ctrl_q};
        REG_GTP: rdata_d = {16'h0000, gt_q, psc_q};
        REG_STS: rdata_d = {28'h000_0000, sts_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= 8'h00;
      psc_q <= PSC_RESET;
      gt_q <= GT_RESET;
      sts_q <= 4'h0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      psc_q <= psc_d;
      gt_q <= gt_d;
      sts_q <= sts_d;
      reg_rdata <= rdata_d;
    end
  end

  // pin outputs, all registered
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ir_tx <= 1'b0;
      core_rx <= 1'b1;
      core_break_rx <= 1'b0;
      data_out <= 1'b1;
      data_oe_b <= 1'b1;
      card_clk <= 1'b0;
      break_irq <= 1'b0;
    end else begin
      ir_tx <= irp_q;
      core_rx <= ir_active ? dec_q : dat_s2_q;
      core_break_rx <= core_rx_zero_fe && !ctrl_q[CTRL_SC_EN];
      data_out <= !(nack_q || brk_bits_q != 4'h0) && core_tx;
      data_oe_b <= ir_active;
      card_clk <= cclk_q;
      break_irq <= sts_q[STS_BRK] && ctrl_q[CTRL_BRK_IE];
    end
  end
endmodule // usm_top
`default_nettype wire

// ===== verilog/usm_pkg.sv
// shared constants for the serial special-mode extension block
package usm_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_S8 = 4'h7;
  localparam logic [3:0] OVS_S9 = 4'h8;
  localparam logic [3:0] OVS_S10 = 4'h9;
  localparam logic [3:0] IR_PULSE_SIXTEENTHS = 4'h3;
  localparam logic [1:0] IR_LP_PULSE_CYC = 2'h3;
  localparam logic [1:0] IR_FILT_CYC = 2'h2;
  localparam logic [3:0] BRK_SEND_BITS = 4'hD;
  localparam logic [3:0] BRK_LEN_SHORT = 4'hA;
  localparam logic [3:0] BRK_LEN_LONG = 4'hB;
  localparam logic [1:0] NACK_MAX_BITS = 2'h2;
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam logic [7:0] GT_RESET = 8'h00;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_GTP = 5'h04;
  localparam logic [4:0] REG_STS = 5'h08;
  localparam int CTRL_IR_EN = 0;
  localparam int CTRL_IR_LP = 1;
  localparam int CTRL_LIN_EN = 2;
  localparam int CTRL_BRK_LEN = 3;
  localparam int CTRL_BRK_IE = 4;
  localparam int CTRL_SC_EN = 5;
  localparam int CTRL_SC_NACK = 6;
  localparam int CTRL_SEND_BRK = 7;
  localparam int STS_BRK = 0;
  localparam int STS_TXC = 1;
  localparam int STS_FE = 2;
  localparam int STS_TXE = 3;
  typedef enum logic [3:0] {
    USM_BD_IDLE = 4'h1,
    USM_BD_BITS = 4'h2,
    USM_BD_DELIM = 4'h4,
    USM_BD_WAIT = 4'h8
  } usm_bd_state_t;
endpackage : usm_pkg

// ===== verilog/usm_break_det.sv
// LIN break detector that runs beside the receiver
`timescale 1ns/1ps
`default_nettype none
module usm_break_det
  import usm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic ovs_tick,
  input wire logic rx,
  input wire logic long_sel,
  output logic found
);
  usm_bd_state_t st_q, st_d;
  logic [3:0] ph_q, ph_d;
  logic [3:0] nbit_q, nbit_d;
  logic [2:0] smp_q, smp_d;
  logic found_d;
  logic [3:0] need;
  logic vote;

  assign need = long_sel ? BRK_LEN_LONG : BRK_LEN_SHORT;
  // majority of the three mid-bit samples
  assign vote = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) | (smp_q[0] & smp_q[2]);

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    nbit_d = nbit_q;
    smp_d = smp_q;
    found_d = 1'b0;
    if (!enable) begin
      st_d = USM_BD_IDLE;
    end else if (ovs_tick) begin
      ph_d = ph_q + 4'h1;
      if (ph_q == OVS_S8 || ph_q == OVS_S9 || ph_q == OVS_S10) begin
        smp_d = {smp_q[1:0], rx};
      end
      unique case (st_q)
        USM_BD_IDLE: begin
          if (!rx) begin
            st_d = USM_BD_BITS;
            ph_d = 4'h1;
            nbit_d = 4'h0;
          end
        end
        USM_BD_BITS: begin
          if (ph_q == OVS_LAST) begin
            if (vote) begin
              st_d = USM_BD_IDLE;
            end else if (nbit_q + 4'h1 == need) begin
              st_d = USM_BD_DELIM;
            end else begin
              nbit_d = nbit_q + 4'h1;
            end
          end
        end
        USM_BD_DELIM: begin
          if (rx) begin
            found_d = 1'b1;
            st_d = USM_BD_IDLE;
          end
        end
        USM_BD_WAIT: st_d = USM_BD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= USM_BD_IDLE;
      ph_q <= 4'h0;
      nbit_q <= 4'h0;
      smp_q <= 3'h7;
      found <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      nbit_q <= nbit_d;
      smp_q <= smp_d;
      found <= found_d;
    end
  end
endmodule // usm_break_det
`default_nettype wire

// ===== dv/usm_top_checker.sv
// port assertions for the serial special-mode block
`timescale 1ns/1ps
`default_nettype none
module usm_top_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic ovs_tick,
  input wire logic core_tx,
  input wire logic core_rx_busy,
  input wire logic core_rx_zero_fe,
  input wire logic core_break_rx,
  input wire logic ir_tx,
  input wire logic data_out,
  input wire logic data_oe_b
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  logic [2:0] ir_ticks_q, ir_ticks_d;
  logic [8:0] low_ticks_q, low_ticks_d;
  // oversampling ticks seen while a pulse or a forced low lasts
  always_comb begin
    ir_ticks_d = ir_tx ? ir_ticks_q + {2'h0, ovs_tick} : 3'h0;
    low_ticks_d = data_out ? 9'h000 : low_ticks_q + {8'h00, ovs_tick};
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ir_ticks_q <= 3'h0;
      low_ticks_q <= 9'h000;
    end else begin
      ir_ticks_q <= ir_ticks_d;
      low_ticks_q <= low_ticks_d;
    end
  end
  chk_ir_idle_low: assert property (
    core_tx && $past(core_tx) && $past(core_tx, 2) && $past(core_tx, 3) |-> !ir_tx)
    else $error("ir pulse on idle line");
  chk_ir_rise_cause: assert property (
    $rose(ir_tx) |-> !$past(core_tx) || !$past(core_tx, 2) || !$past(core_tx, 3))
    else $error("ir pulse without a zero bit");
  chk_ir_rx_quiet: assert property (
    core_rx_busy && $past(core_rx_busy) && $past(core_rx_busy, 2) |-> !ir_tx)
    else $error("ir pulse while receiving");
  chk_ir_pulse_ticks: assert property (ir_ticks_q <= 3'h3)
    else $error("ir pulse too long");
  chk_break_ticks: assert property (low_ticks_q <= 9'h0D1)
    else $error("forced low too long");
  chk_zero_fe_src: assert property (
    $rose(core_break_rx) |-> $past(core_rx_zero_fe))
    else $error("break flag without zero byte");
  chk_force_drives: assert property (
    $past(core_tx) && core_tx && !data_out |-> !data_oe_b)
    else $error("forced low not driven");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule // usm_top_checker
bind usm_top usm_top_checker i_usm_top_checker (.clock, .rst_b, .reg_rd, .reg_rdata,
  .ovs_tick, .core_tx, .core_rx_busy, .core_rx_zero_fe, .core_break_rx, .ir_tx,
  .data_out, .data_oe_b);
`default_nettype wire

// ===== dv/usm_line_model.sv
// far-side line model: pulls the shared line low for a timed run
`timescale 1ns/1ps
`default_nettype none
module usm_line_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic go,
  input wire logic ir_go,
  input wire logic [4:0] nbits,
  input wire logic data_out,
  input wire logic data_oe_b,
  output logic data_in_pin,
  output logic ir_rx_pin
);
  logic [10:0] low_q, low_d;
  logic [4:0] ir_low_q, ir_low_d;
  // a bit is 64 clocks: ticks every 4 clocks, 16 ticks a bit
  always_comb begin
    low_d = low_q;
    ir_low_d = ir_low_q;
    if (go) low_d = {nbits, 6'h00};
    else if (low_q != 11'h000) low_d = low_q - 11'h001;
    // infrared pulses are counted in plain clocks, not bits
    if (ir_go) ir_low_d = nbits;
    else if (ir_low_q != 5'h00) ir_low_d = ir_low_q - 5'h01;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      low_q <= 11'h000;
      ir_low_q <= 5'h00;
    end else begin
      low_q <= low_d;
      ir_low_q <= ir_low_d;
    end
  end
  // open drain with pull-up, either side may pull low
  assign data_in_pin = (low_q == 11'h000) && (data_oe_b || data_out);
  // receive pulses idle high, pulse low, and come before any infrared send
  assign ir_rx_pin = (ir_low_q == 5'h00);
endmodule // usm_line_model
`default_nettype wire

// ===== dv/usm_top_tb_top.sv
// self-checking bench for the serial special-mode block
`timescale 1ns/1ps
`default_nettype none
module usm_top_tb_top
  import usm_pkg::*;
;
  logic clock, rst_b, reg_wr, reg_rd, ovs_tick, lp_tick, core_tx, core_tx_busy, core_rx_busy;
  logic core_frame_end, core_parity_err, core_rx_stop_end, core_rx_zero_fe, go, ir_go, core_rx;
  logic core_break_rx, ir_tx, ir_rx_pin, data_in_pin, data_out, data_oe_b, card_clk, break_irq;
  logic [4:0] reg_addr, nbits;
  logic [31:0] reg_wdata, reg_rdata, rv;
  int fails, checked, cyc, bad, run_do, run_ir, run_ck, len_do, len_ir, len_ck;
  typedef struct packed {logic [7:0] ctrl; logic [4:0] n; logic f;} usm_row_t;
  usm_row_t rows [4] = '{'{8'h14, 5'h09, 1'b0}, '{8'h14, 5'h0B, 1'b1},
    '{8'h1C, 5'h0A, 1'b0}, '{8'h1C, 5'h0C, 1'b1}};
  usm_top i_usm_top (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ovs_tick, .lp_tick, .core_tx, .core_tx_busy, .core_rx_busy, .core_frame_end,
    .core_parity_err, .core_rx_stop_end, .core_rx_zero_fe, .core_rx, .core_break_rx, .ir_tx,
    .ir_rx_pin, .data_in_pin, .data_out, .data_oe_b, .card_clk, .break_irq);
  usm_line_model i_usm_line_model (.clock, .rst_b, .go, .ir_go, .nbits, .data_out, .data_oe_b,
    .data_in_pin, .ir_rx_pin);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic complete_run();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    ovs_tick <= (cyc % 4 == 3);
    lp_tick <= (cyc % 3 == 2);
    run_do <= data_out ? 0 : run_do + 1;
    run_ir <= ir_tx ? run_ir + 1 : 0;
    run_ck <= card_clk ? run_ck + 1 : 0;
    if (data_out && run_do != 0) len_do <= run_do;
    if (!ir_tx && run_ir != 0) len_ir <= run_ir;
    if (!card_clk && run_ck != 0) len_ck <= run_ck;
    if (cyc == 12000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  initial begin
    {rst_b, reg_wr, reg_rd, core_tx_busy, core_rx_busy, core_frame_end, go} = '0;
    {core_parity_err, core_rx_stop_end, core_rx_zero_fe, ir_go} = '0;
    {reg_addr, nbits, reg_wdata} = '0;
    core_tx = 1'b1;
    wt(2);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      wr(REG_CTRL, {24'h0, rows[i].ctrl});
      @(posedge clock);
      nbits <= rows[i].n;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      wt(900);
      rd(REG_STS);
      chk({31'h0, rv[STS_BRK]}, {31'h0, rows[i].f});
      chk({31'h0, break_irq}, {31'h0, rows[i].f});
      wr(REG_STS, 32'h0);
    end
    rd(REG_GTP);
    chk(rv, {16'h0, GT_RESET, PSC_RESET});
    wr(5'h10, 32'hFFFF_FFFF);
    rd(5'h10);
    chk(rv, 32'h0);
    wr(REG_CTRL, 32'h84);
    wt(900);
    rng(len_do, 828, 836);
    // decoder: short pulse dropped, long pulse ignored while sending, long pulse taken
    for (int i = 0; i < 2; i++) begin
      wr(REG_CTRL, i ? 32'h3 : 32'h1);
      for (int j = 0; j < 3; j++) begin
        @(posedge clock);
        core_tx_busy <= (j == 1);
        nbits <= (j == 0) ? (i ? 5'h03 : 5'h01) : 5'h0C;
        ir_go <= 1'b1;
        @(posedge clock);
        ir_go <= 1'b0;
        bad = 0;
        repeat (24) begin
          @(posedge clock);
          #1 bad += int'(core_rx !== 1'b1);
        end
        core_tx_busy <= 1'b0;
        wt(80);
        chk({31'h0, bad != 0}, {31'h0, j == 2});
      end
    end
    for (int i = 0; i < 2; i++) begin
      wr(REG_CTRL, i ? 32'h3 : 32'h1);
      // a bit starts on a tick of the clock that times its pulse
      do @(posedge clock); while (!(i ? lp_tick : ovs_tick));
      core_tx_busy <= 1'b1;
      core_tx <= 1'b0;
      wt(48);
      core_tx <= 1'b1;
      core_tx_busy <= 1'b0;
      wt(40);
      rng(len_ir, i ? 8 : 11, i ? 10 : 13);
    end
    core_rx_busy <= 1'b1;
    core_tx <= 1'b0;
    bad = 0;
    repeat (48) begin
      @(posedge clock);
      #1 bad += int'(ir_tx !== 1'b0);
    end
    chk(bad, 0);
    core_tx <= 1'b1;
    core_rx_busy <= 1'b0;
    wr(REG_GTP, 32'h0203);
    wr(REG_CTRL, 32'h60);
    wt(40);
    chk(len_ck, 3);
    // a stop bit ends on an oversampling tick, so start the NACK there
    do @(posedge clock); while (!ovs_tick);
    core_parity_err <= 1'b1;
    core_rx_stop_end <= 1'b1;
    @(posedge clock);
    core_rx_stop_end <= 1'b0;
    wt(100);
    rng(len_do, 62, 66);
    core_parity_err <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(REG_CTRL, i ? 32'h0 : 32'h20);
      @(posedge clock);
      core_rx_zero_fe <= 1'b1;
      @(posedge clock);
      core_rx_zero_fe <= 1'b0;
      #1 chk({31'h0, core_break_rx}, i);
    end
    wr(REG_CTRL, 32'h20);
    @(posedge clock);
    core_frame_end <= 1'b1;
    @(posedge clock);
    core_frame_end <= 1'b0;
    wr(REG_STS, 32'h0);
    wt(40);
    rd(REG_STS);
    chk({31'h0, rv[STS_TXC]}, 32'h0);
    wt(120);
    rd(REG_STS);
    chk({31'h0, rv[STS_TXC]}, 32'h1);
    // card answers a sent frame with a two-bit low in the stop bits
    @(posedge clock);
    core_tx_busy <= 1'b1;
    nbits <= 5'h02;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    wt(200);
    core_tx_busy <= 1'b0;
    rd(REG_STS);
    chk({31'h0, rv[STS_FE]}, 32'h1);
    complete_run();
  end
endmodule // usm_top_tb_top
`default_nettype wire
